// [hw/usbeps_core.sv]
// endpoint buffers, mode and counter registers with engine-side update port
`timescale 1ns/100ps
module usbeps_core
    import usbeps_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_io_write_op,
    input wire logic i_io_read_op,
    input wire logic [7:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    input wire logic i_sie_setup_data,
    input wire logic i_sie_done,
    input wire logic [1:0] i_sie_ep,
    input wire usbeps_pkg::usbeps_tok_t i_sie_tok,
    input wire logic i_sie_ack,
    input wire logic i_sie_valid,
    input wire logic [3:0] i_sie_count,
    input wire logic i_sie_bwr,
    input wire logic [2:0] i_sie_baddr,
    input wire logic [7:0] i_sie_bdata,
    input wire logic [1:0] i_sie_rd_ep,
    input wire logic [2:0] i_sie_rd_addr,
    output logic [7:0] o_sie_rd_data,
    output logic o_addr_enabled,
    output logic [6:0] o_dev_addr,
    output logic [3:0] o_ep_mode [NUM_EP],
    output logic [3:0] o_ep_count [NUM_EP],
    output logic [NUM_EP-1:0] o_ep_toggle,
    output logic [NUM_EP-1:0] o_ep_irq
);
    import usbeps_pkg::*;

    typedef struct packed {
        logic [NUM_EP-1:0][BUF_BYTES-1:0][7:0] buf_mem;
        logic [NUM_EP-1:0][7:0] mode;
        logic [NUM_EP-1:0][7:0] cnt;
        logic [7:0] dev_addr;
        logic lock;
        logic setup_hold;
        logic [NUM_EP-1:0] irq;
        logic [7:0] rdata;
        logic [7:0] sie_rd;
    } usbeps_state_t;

    usbeps_state_t st_r;
    usbeps_state_t st_nxt;

    // buffer base per endpoint, used by io and range checks
    function automatic logic [7:0] buf_base(input int ep);
        case (ep)
            0: buf_base = BUF0_BASE;
            1: buf_base = BUF1_BASE;
            default: buf_base = BUF2_BASE;
        endcase
    endfunction

    function automatic logic in_buf(input logic [7:0] a, input logic [7:0] base);
        in_buf = (a[7:3] == base[7:3]);
    endfunction

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.irq = '0;
        // register and buffer read path
        if (i_io_read_op)
        begin
            case (i_io_addr)
                ADDR_DEV_ADDR: st_nxt.rdata = st_r.dev_addr;
                ADDR_CNT0: st_nxt.rdata = st_r.cnt[0];
                ADDR_CNT1: st_nxt.rdata = st_r.cnt[1];
                ADDR_CNT2: st_nxt.rdata = st_r.cnt[2];
                ADDR_MODE0: st_nxt.rdata = st_r.mode[0];
                ADDR_MODE1: st_nxt.rdata = st_r.mode[1];
                ADDR_MODE2: st_nxt.rdata = st_r.mode[2];
                default:
                begin
                    st_nxt.rdata = 8'h00;
                    for (int e = 0; e < NUM_EP; e++)
                    begin
                        if (in_buf(i_io_addr, buf_base(e)))
                            st_nxt.rdata = st_r.buf_mem[e][i_io_addr[2:0]];
                    end
                end
            endcase
            if (i_io_addr == ADDR_MODE0)
            begin
                st_nxt.lock = 1'b0;
                if (!i_sie_setup_data)
                    st_nxt.setup_hold = 1'b0;
            end
        end
        if (i_io_write_op)
        begin
            case (i_io_addr)
                ADDR_DEV_ADDR: st_nxt.dev_addr = i_io_wdata;
                ADDR_CNT1: st_nxt.cnt[1] = i_io_wdata & CNT_MASK;
                ADDR_CNT2: st_nxt.cnt[2] = i_io_wdata & CNT_MASK;
                ADDR_CNT0: st_nxt.cnt[0] = i_io_wdata & CNT_MASK;
                ADDR_MODE1: st_nxt.mode[1] = i_io_wdata & DATA_MODE_MASK;
                ADDR_MODE2: st_nxt.mode[2] = i_io_wdata & DATA_MODE_MASK;
                ADDR_MODE0:
                begin
                    if (!st_r.lock)
                        st_nxt.mode[0][6:0] = i_io_wdata[6:0];
                    if (!st_r.setup_hold && !i_sie_setup_data)
                        st_nxt.mode[0][MODE_SETUP_BIT] = i_io_wdata[MODE_SETUP_BIT];
                end
                default:
                begin
                    for (int e = 0; e < NUM_EP; e++)
                    begin
                        if (in_buf(i_io_addr, buf_base(e)) &&
                            !(st_r.mode[0][MODE_SETUP_BIT] &&
                              (in_buf(i_io_addr, BUF0_BASE) ||
                               in_buf(i_io_addr, SETUP_LOCK_BASE))))
                            st_nxt.buf_mem[e][i_io_addr[2:0]] = i_io_wdata;
                    end
                end
            endcase
        end
        // engine side; updates override firmware, mode flags are only set, count fields take the engine value whether set or clear on non-IN tokens
        // address enable gate
        if (st_r.dev_addr[ADDR_EN_BIT])
        begin
            if (i_sie_bwr && i_sie_ep < 2'(NUM_EP))
                st_nxt.buf_mem[i_sie_ep][i_sie_baddr] = i_sie_bdata;
            if (i_sie_setup_data)
            begin
                st_nxt.mode[0][MODE_SETUP_BIT] = 1'b1;
                st_nxt.setup_hold = 1'b1;
            end
            if (i_sie_done && i_sie_ep < 2'(NUM_EP))
            begin
                st_nxt.irq[i_sie_ep] = 1'b1;
                if (i_sie_ack)
                    st_nxt.mode[i_sie_ep][MODE_ACK_BIT] = 1'b1;
                if (i_sie_tok != USBEPS_TOK_IN)
                begin
                    st_nxt.cnt[i_sie_ep][CNT_VALID_BIT] = i_sie_valid;
                    st_nxt.cnt[i_sie_ep][3:0] = i_sie_count;
                end
                if (i_sie_ep == 2'd0)
                begin
                    case (i_sie_tok)
                        USBEPS_TOK_SETUP: st_nxt.mode[0][MODE_SETUP_BIT] = 1'b1;
                        USBEPS_TOK_IN: st_nxt.mode[0][MODE_IN_BIT] = 1'b1;
                        USBEPS_TOK_OUT: st_nxt.mode[0][MODE_OUT_BIT] = 1'b1;
                        default: st_nxt.mode[0][MODE_OUT_BIT] = st_r.mode[0][MODE_OUT_BIT];
                    endcase
                    st_nxt.lock = 1'b1;
                end
            end
        end
        st_nxt.sie_rd = st_r.buf_mem[i_sie_rd_ep < 2'(NUM_EP) ? i_sie_rd_ep : 2'd0][i_sie_rd_addr];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            st_r <= '0;
            for (int e = 0; e < NUM_EP; e++)
            begin
                st_r.mode[e] <= MODE_RESET;
                st_r.cnt[e] <= CNT_RESET;
            end
            st_r.dev_addr <= DEV_ADDR_RESET;
        end
        else if (i_ce)
        begin
            st_r <= st_nxt;
        end
    end

    assign o_io_rdata = st_r.rdata;
    assign o_sie_rd_data = st_r.sie_rd;
    assign o_addr_enabled = st_r.dev_addr[ADDR_EN_BIT];
    assign o_dev_addr = st_r.dev_addr[6:0];
    assign o_ep_irq = st_r.irq;

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : g_ep
            assign o_ep_mode[g] = st_r.mode[g][3:0];
            assign o_ep_count[g] = (st_r.cnt[g][3:0] > MAX_COUNT) ? MAX_COUNT : st_r.cnt[g][3:0];
            assign o_ep_toggle[g] = st_r.cnt[g][CNT_TOGGLE_BIT];
        end
    endgenerate
endmodule

// [hw/usbeps_pkg.sv]
// constants for the usb endpoint status and control block
package usbeps_pkg;
    localparam int NUM_EP = 3;
    localparam int BUF_BYTES = 8;
    localparam logic [7:0] ADDR_DEV_ADDR = 8'h10;
    localparam logic [7:0] ADDR_CNT0 = 8'h11;
    localparam logic [7:0] ADDR_MODE0 = 8'h12;
    localparam logic [7:0] ADDR_CNT1 = 8'h13;
    localparam logic [7:0] ADDR_MODE1 = 8'h14;
    localparam logic [7:0] ADDR_CNT2 = 8'h15;
    localparam logic [7:0] ADDR_MODE2 = 8'h16;
    localparam logic [7:0] BUF0_BASE = 8'hF8;
    localparam logic [7:0] BUF1_BASE = 8'hF0;
    localparam logic [7:0] BUF2_BASE = 8'hE8;
    localparam logic [7:0] SETUP_LOCK_BASE = 8'hE0;
    localparam int MODE_SETUP_BIT = 7;
    localparam int MODE_IN_BIT = 6;
    localparam int MODE_OUT_BIT = 5;
    localparam int MODE_ACK_BIT = 4;
    localparam int CNT_TOGGLE_BIT = 7;
    localparam int CNT_VALID_BIT = 6;
    localparam int ADDR_EN_BIT = 7;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] DEV_ADDR_RESET = 8'h00;
    localparam logic [7:0] DATA_MODE_MASK = 8'h1F;
    localparam logic [7:0] CNT_MASK = 8'hCF;
    localparam logic [3:0] MAX_COUNT = 4'h8;
    typedef enum logic [1:0] {
        USBEPS_TOK_SETUP = 2'h0,
        USBEPS_TOK_IN = 2'h1,
        USBEPS_TOK_OUT = 2'h2
    } usbeps_tok_t;
endpackage

// [test/usbeps_core_props.sv]
// assertion checker for the usb endpoint status block
`timescale 1ns/100ps
module usbeps_core_props
    import usbeps_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_io_write_op,
    input wire logic i_io_read_op,
    input wire logic [7:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    input wire logic [7:0] o_io_rdata,
    input wire logic i_sie_done,
    input wire logic [1:0] i_sie_ep,
    input wire logic o_addr_enabled,
    input wire logic [6:0] o_dev_addr,
    input wire logic [NUM_EP-1:0] o_ep_toggle,
    input wire logic [NUM_EP-1:0] o_ep_irq
);
    import usbeps_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    sequence ep_done(e);
        i_sie_done && i_sie_ep == e && o_addr_enabled;
    endsequence
    sequence wr_at(a);
        i_io_write_op && i_io_addr == a;
    endsequence
    rst_clear_a: assert property ($fell(i_srst) |-> o_ep_irq == 3'h0 && !o_addr_enabled)
        else $error("outputs not clear after reset");
    irq_ep0_a: assert property (ep_done(2'h0) |=> o_ep_irq == 3'h1)
        else $error("endpoint zero request missing");
    irq_ep1_a: assert property (ep_done(2'h1) |=> o_ep_irq == 3'h2)
        else $error("endpoint one request missing");
    irq_gate_a: assert property (i_sie_done && !o_addr_enabled |=> o_ep_irq == 3'h0)
        else $error("traffic seen while address disabled");
    rd_unmap_a: assert property (i_io_read_op && i_io_addr == 8'h20 |=> o_io_rdata == 8'h00)
        else $error("unmapped read not zero");
    rsvd_mode_a: assert property (i_io_read_op && i_io_addr == ADDR_MODE1 |=> o_io_rdata[7:5] == 3'h0)
        else $error("reserved mode bits not zero");
    toggle_wr_a: assert property (wr_at(ADDR_CNT1) |=> o_ep_toggle[1] == $past(i_io_wdata[7]))
        else $error("toggle does not follow write");
    addr_wr_a: assert property (wr_at(ADDR_DEV_ADDR) |=> o_addr_enabled == $past(i_io_wdata[7]))
        else $error("address enable does not follow write");
endmodule
bind usbeps_core usbeps_core_props usbeps_core_props_inst (.i_ref_clk, .i_srst, .i_io_write_op,
    .i_io_read_op, .i_io_addr, .i_io_wdata, .o_io_rdata, .i_sie_done, .i_sie_ep, .o_addr_enabled,
    .o_dev_addr, .o_ep_toggle, .o_ep_irq);

// [test/usbeps_core_tb_top.sv]
// self-checking bench for the usb endpoint status block
`timescale 1ns/100ps
module usbeps_core_tb_top;
    import usbeps_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wr_op = 1'b0, rd_op = 1'b0, sdat, done, ack, vld, bwr, aen;
    logic [7:0] adr = 8'h00, wdat = 8'h00, rdat, bdat, srd;
    logic [1:0] ep, rep;
    logic [2:0] badr, radr, tgl, irq;
    logic [3:0] cnt;
    logic [6:0] dadr;
    logic [3:0] mode [NUM_EP];
    logic [3:0] ecnt [NUM_EP];
    usbeps_tok_t tok;
    int errors = 0, cmp_count = 0, cyc = 0;
    always #4 clk = ~clk;
    usbeps_host_model usbeps_host_model_inst (.i_ref_clk(clk), .o_setup_data(sdat), .o_done(done),
        .o_ep(ep), .o_tok(tok), .o_ack(ack), .o_valid(vld), .o_count(cnt), .o_bwr(bwr),
        .o_baddr(badr), .o_bdata(bdat), .o_rd_ep(rep), .o_rd_addr(radr));
    usbeps_core usbeps_core_inst (.i_ref_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_io_write_op(wr_op),
        .i_io_read_op(rd_op), .i_io_addr(adr), .i_io_wdata(wdat), .o_io_rdata(rdat),
        .i_sie_setup_data(sdat), .i_sie_done(done), .i_sie_ep(ep), .i_sie_tok(tok), .i_sie_ack(ack),
        .i_sie_valid(vld), .i_sie_count(cnt), .i_sie_bwr(bwr), .i_sie_baddr(badr),
        .i_sie_bdata(bdat), .i_sie_rd_ep(rep), .i_sie_rd_addr(radr), .o_sie_rd_data(srd),
        .o_addr_enabled(aen), .o_dev_addr(dadr), .o_ep_mode(mode), .o_ep_count(ecnt),
        .o_ep_toggle(tgl), .o_ep_irq(irq));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {wr_op, adr, wdat} = {1'b1, a, d};
        @(negedge clk);
        wr_op = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge clk);
        {rd_op, adr} = {1'b1, a};
        @(negedge clk);
        rd_op = 1'b0;
        chk("io read", e, rdat & m);
    endtask
    task automatic t_data;
        rd(ADDR_MODE2, 8'h00, 8'hFF);
        wr(ADDR_MODE1, 8'hFF);
        rd(ADDR_MODE1, 8'h1F, 8'hFF);
        wr(ADDR_MODE1, 8'h03);
        wr(ADDR_CNT1, 8'hC8);
        rd(ADDR_CNT1, 8'hC8, 8'hFF);
        chk("count out", 8'h08, {4'h0, ecnt[1]});
        chk("mode out", 8'h03, {4'h0, mode[1]});
        chk("toggle out", 8'h02, {5'h00, tgl});
        wr(BUF1_BASE, 8'h3C);
        usbeps_host_model_inst.bread(2'h1, 3'h0);
        chk("engine read", 8'h3C, srd);
        usbeps_host_model_inst.xact(2'h1, USBEPS_TOK_IN, 4'h0);
        rd(ADDR_MODE1, 8'h03, 8'hFF);
        $display("test data endpoint done");
    endtask
    task automatic t_setup;
        wr(ADDR_DEV_ADDR, 8'h85);
        chk("device address", 8'h05, {1'b0, dadr});
        usbeps_host_model_inst.xact(2'h1, USBEPS_TOK_IN, 4'h0);
        rd(ADDR_MODE1, 8'h13, 8'hFF);
        wr(ADDR_MODE0, 8'h02);
        rd(ADDR_MODE0, 8'h02, 8'hFF);
        usbeps_host_model_inst.xact(2'h0, USBEPS_TOK_SETUP, 4'h8);
        wr(ADDR_MODE0, 8'h00);
        wr(BUF0_BASE, 8'h55);
        rd(ADDR_MODE0, 8'h90, 8'hF0);
        rd(BUF0_BASE, 8'hA0, 8'hFF);
        rd(ADDR_CNT0, 8'h48, 8'h4F);
        wr(ADDR_MODE0, 8'h00);
        rd(ADDR_MODE0, 8'h00, 8'hFF);
        usbeps_host_model_inst.xact(2'h0, USBEPS_TOK_IN, 4'h0);
        rd(ADDR_MODE0, 8'h50, 8'hF0);
        wr(ADDR_MODE0, 8'h00);
        usbeps_host_model_inst.xact(2'h0, USBEPS_TOK_OUT, 4'h0);
        rd(ADDR_MODE0, 8'h30, 8'hF0);
        rd(8'h20, 8'h00, 8'hFF);
        $display("test setup done");
    endtask
    task automatic close_out;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // whole run is under a hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            errors++;
            close_out();
        end
    end
    initial
    begin
        repeat (4) @(negedge clk);
        srst = 1'b0;
        t_data();
        t_setup();
        close_out();
    end
endmodule

// [test/usbeps_host_model.sv]
// usb host side stand-in driving the engine-side ports
`timescale 1ns/100ps
module usbeps_host_model
    import usbeps_pkg::*;
(
    input wire logic i_ref_clk,
    output logic o_setup_data = 1'b0,
    output logic o_done = 1'b0,
    output logic [1:0] o_ep = 2'h0,
    output usbeps_pkg::usbeps_tok_t o_tok = USBEPS_TOK_IN,
    output logic o_ack = 1'b0,
    output logic o_valid = 1'b0,
    output logic [3:0] o_count = 4'h0,
    output logic o_bwr = 1'b0,
    output logic [2:0] o_baddr = 3'h0,
    output logic [7:0] o_bdata = 8'h00,
    output logic [1:0] o_rd_ep = 2'h0,
    output logic [2:0] o_rd_addr = 3'h0
);
    import usbeps_pkg::*;
    task automatic xact(input logic [1:0] ep, input usbeps_tok_t tok, input logic [3:0] cnt);
        @(negedge i_ref_clk);
        // setup data phase with one byte
        if (tok == USBEPS_TOK_SETUP)
        begin
            o_setup_data = 1'b1;
            // buffer write lands in the endpoint being set up, not the last one used
            o_ep = ep;
            o_bwr = 1'b1;
            o_bdata = 8'hA0;
            @(negedge i_ref_clk);
            o_bwr = 1'b0;
            o_bdata = 8'h5F;
            @(negedge i_ref_clk);
            o_setup_data = 1'b0;
        end
        {o_done, o_ep, o_tok, o_ack, o_count} = {1'b1, ep, tok, 1'b1, cnt};
        o_valid = (tok != USBEPS_TOK_IN);
        @(negedge i_ref_clk);
        // released qualifiers flip so stale values never match
        {o_done, o_ack, o_valid, o_count} = {1'b0, 1'b0, ~o_valid, ~cnt};
    endtask
    task automatic bread(input logic [1:0] ep, input logic [2:0] a);
        @(negedge i_ref_clk);
        {o_rd_ep, o_rd_addr} = {ep, a};
        @(negedge i_ref_clk);
    endtask
endmodule
